// >>> hw/pixel_asm_pkg.sv
/*
 Shared constants and carrier types for the direct-colour pixel assembler.
 Assumes a single synchronous clock domain; no software registers.
*/
package pixel_asm_pkg;
	localparam int SUB_W = 4;
	localparam int PIX_W = 16;
	localparam int WORD_W = 32;
	// Video type codes chosen by the controlling side
	localparam logic [1:0] VT_NORMAL = 2'h0;
	localparam logic [1:0] VT_EXT_PAL = 2'h1;
	localparam logic [1:0] VT_DAC12 = 2'h2;
	localparam logic [1:0] VT_DAC16 = 2'h3;
	localparam logic [1:0] SUBS_12 = 2'h2;
	localparam logic [1:0] SUBS_16 = 2'h3;
	localparam logic [1:0] SKIP_12 = 2'h2;
	localparam int RED_LSB = 0;
	localparam int GRN_LSB = 4;
	localparam int BLU_LSB = 8;
	localparam int R5_BIT = 12;
	localparam int G5_BIT = 13;
	localparam int B5_BIT = 14;
	localparam int INT_BIT = 15;
	localparam logic [15:0] PIX_RST = 16'h0000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

	typedef struct packed {
		logic valid;
		logic line_start;
		logic [3:0] nib;
	} sub_in_t;

	typedef struct packed {
		logic [4:0] red;
		logic [4:0] grn;
		logic [4:0] blu;
	} rgb5_t;
endpackage

// >>> hw/pair_packer.sv
/*
 Packs two consecutive 16-bit pixels into one 32-bit word, first pixel low.
 Assumes pixel strobes are one-cycle pulses; a line start drops an odd half.
*/
`timescale 1ns/1ps
`default_nettype none
module pair_packer (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic line_start,
	input wire logic pix_valid,
	input wire logic [15:0] pix,
	output logic word_valid,
	output logic [31:0] word
);
	logic half;
	logic [15:0] low;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			half <= 1'b0;
			low <= pixel_asm_pkg::PIX_RST;
			word_valid <= 1'b0;
			word <= pixel_asm_pkg::WORD_RST;
		end else begin
			word_valid <= 1'b0;
			// Pixel strobe lags its line by a cycle: pair it before a restart
			if (pix_valid) begin
				if (half) begin
					word <= {pix, low};
					word_valid <= 1'b1;
				end else begin
					low <= pix;
				end
			end
			if (line_start) begin
				half <= 1'b0;
			end else if (pix_valid) begin
				half <= ~half;
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/direct_dac_pixel_assembler.sv
/*
 Assembles 4-bit sub-pixels into 12 or 16 bpp direct-colour pixels for a DAC.
 Assumes one clock at the sub-pixel rate and a line-start strobe on the
 first sub-pixel of each active line.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - In 12 bpp mode three consecutive sub-pixels make one output pixel.
// - In 12 bpp mode the first two sub-pixels of each line are dropped.
// - After the dropped pair, 12 bpp groups arrive as red, green, blue.
// - A 12 bpp word holds blue in 11:8, green in 7:4 and red in 3:0.
// - In 16 bpp mode four sub-pixels make one pixel with nothing dropped.
// - The top nibble of a 16 bpp pixel is intensity, blue5, green5, red5.
// - The intensity bit extends all three colours' fifth bit together.
// - The low twelve bits of a 16 bpp pixel follow the 12 bpp layout.
// - A 16 bpp pixel is two bytes, so two pixels fill one 32-bit word.
module direct_dac_pixel_assembler (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [1:0] video_type,
	input wire pixel_asm_pkg::sub_in_t sub_in,
	output logic pix_valid,
	output logic [15:0] pix,
	output pixel_asm_pkg::rgb5_t dac_rgb,
	output logic word_valid,
	output logic [31:0] word
);
	typedef enum logic [2:0] {
		ST_SKIP = 3'b001,
		ST_GROUP = 3'b010,
		ST_IDLE = 3'b100
	} asm_state_t;

	asm_state_t state;
	logic [1:0] skip_cnt;
	logic [1:0] sub_idx;
	logic [15:0] acc;
	logic is12;
	logic is16;
	logic [1:0] last_idx;
	logic [15:0] next_acc;
	logic fire;
	logic [15:0] formed;

	assign is12 = (video_type == pixel_asm_pkg::VT_DAC12);
	assign is16 = (video_type == pixel_asm_pkg::VT_DAC16);
	assign last_idx = is12 ? pixel_asm_pkg::SUBS_12 : pixel_asm_pkg::SUBS_16;

	// Sub-pixel idx places nibble: 12 bpp R,G,B; 16 bpp top nibble first
	always_comb begin
		next_acc = acc;
		if (is12) begin
			unique case (sub_idx)
				2'd0: next_acc[3:0] = sub_in.nib;
				2'd1: next_acc[7:4] = sub_in.nib;
				default: next_acc[11:8] = sub_in.nib;
			endcase
			next_acc[15:12] = 4'h0;
		end else begin
			unique case (sub_idx)
				2'd0: next_acc[15:12] = sub_in.nib;
				2'd1: next_acc[3:0] = sub_in.nib;
				2'd2: next_acc[7:4] = sub_in.nib;
				default: next_acc[11:8] = sub_in.nib;
			endcase
		end
	end

	// Controller asserts line_start on first live sub-pixel of the line
	wire logic take = sub_in.valid && (is12 || is16);
	wire logic in_skip = sub_in.line_start ? is12 : (state == ST_SKIP);
	wire logic [1:0] idx_now = sub_in.line_start ? 2'd0 : sub_idx;

	always_comb begin
		fire = take && !in_skip && (idx_now == last_idx);
		formed = next_acc;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			skip_cnt <= 2'd0;
			sub_idx <= 2'd0;
			acc <= pixel_asm_pkg::PIX_RST;
		end else if (!(is12 || is16)) begin
			state <= ST_IDLE;
			sub_idx <= 2'd0;
		end else if (take) begin
			if (sub_in.line_start) begin
				sub_idx <= 2'd0;
				if (is12) begin
					state <= ST_SKIP;
					skip_cnt <= 2'd1;
				end else begin
					state <= ST_GROUP;
					sub_idx <= 2'd1;
					acc <= {sub_in.nib, 12'h000};
				end
			end else if (state == ST_SKIP) begin
				// Second discarded sub-pixel ends the skip
				if (skip_cnt == pixel_asm_pkg::SKIP_12 - 2'd1) begin
					state <= ST_GROUP;
				end
				skip_cnt <= skip_cnt + 2'd1;
			end else if (state == ST_GROUP) begin
				acc <= next_acc;
				sub_idx <= (sub_idx == last_idx) ? 2'd0 : sub_idx + 2'd1;
			end
		end
	end

	// Line start in 16 bpp mode is itself sub-pixel 0 of the first group
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pix_valid <= 1'b0;
			pix <= pixel_asm_pkg::PIX_RST;
			dac_rgb <= '0;
		end else begin
			pix_valid <= fire && (state == ST_GROUP) && !sub_in.line_start;
			if (fire && (state == ST_GROUP) && !sub_in.line_start) begin
				pix <= formed;
				dac_rgb.red <= {formed[15] | formed[12], formed[3:0]};
				dac_rgb.grn <= {formed[15] | formed[13], formed[7:4]};
				dac_rgb.blu <= {formed[15] | formed[14], formed[11:8]};
			end
		end
	end

	// Only 16 bpp pixels are paired into frame-buffer words
	pair_packer u_pack (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.line_start(sub_in.line_start && sub_in.valid),
		.pix_valid(pix_valid && is16),
		.pix(pix),
		.word_valid(word_valid),
		.word(word)
	);

	property p_skip12;
		@(posedge mclk) disable iff (sys_rst)
		(sub_in.valid && sub_in.line_start && is12) |=> !pix_valid [*2];
	endproperty
	a_skip12: assert property (p_skip12) else $error("12 bpp line start not skipped");

	property p_top12;
		@(posedge mclk) disable iff (sys_rst)
		(pix_valid && is12 && $stable(video_type)) |-> pix[15:12] == 4'h0;
	endproperty
	a_top12: assert property (p_top12) else $error("12 bpp pixel top nibble set");

	property p_int;
		@(posedge mclk) disable iff (sys_rst)
		(pix_valid && pix[15]) |-> (dac_rgb.red[4] && dac_rgb.grn[4] && dac_rgb.blu[4]);
	endproperty
	a_int: assert property (p_int) else $error("Intensity not on all fifth bits");

	property p_gap12;
		@(posedge mclk) disable iff (sys_rst)
		(pix_valid && is12 && $stable(video_type)) |=> !pix_valid [*2];
	endproperty
	a_gap12: assert property (p_gap12) else $error("12 bpp pixels closer than three");

	property p_gap16;
		@(posedge mclk) disable iff (sys_rst)
		(pix_valid && is16 && $stable(video_type)) |=> !pix_valid [*3];
	endproperty
	a_gap16: assert property (p_gap16) else $error("16 bpp pixels closer than four");

	property p_dac_low;
		@(posedge mclk) disable iff (sys_rst)
		pix_valid |-> (dac_rgb.red[3:0] == pix[3:0] && dac_rgb.grn[3:0] == pix[7:4]
			&& dac_rgb.blu[3:0] == pix[11:8]);
	endproperty
	a_dac_low: assert property (p_dac_low) else $error("Low colour bits misplaced");

	property p_fifth;
		@(posedge mclk) disable iff (sys_rst)
		pix_valid |-> (dac_rgb.red[4] == (pix[15] | pix[12])
			&& dac_rgb.grn[4] == (pix[15] | pix[13])
			&& dac_rgb.blu[4] == (pix[15] | pix[14]));
	endproperty
	a_fifth: assert property (p_fifth) else $error("Fifth colour bit wrong");

	property p_word;
		@(posedge mclk) disable iff (sys_rst)
		word_valid |-> ($past(pix_valid) && word[31:16] == $past(pix));
	endproperty
	a_word: assert property (p_word) else $error("Word high half not last pixel");

	property p_word16;
		@(posedge mclk) disable iff (sys_rst)
		word_valid |-> $past(is16);
	endproperty
	a_word16: assert property (p_word16) else $error("Word packed outside 16 bpp");

	property p_idle;
		@(posedge mclk) disable iff (sys_rst)
		!(is12 || is16) |=> !pix_valid;
	endproperty
	a_idle: assert property (p_idle) else $error("Pixel formed in palette mode");

	property p_start12;
		@(posedge mclk) disable iff (sys_rst)
		(sub_in.valid && sub_in.line_start && is12) |=> (state == ST_SKIP && sub_idx == 2'd0);
	endproperty
	a_start12: assert property (p_start12) else $error("12 bpp line start not restarted");

	property p_start16;
		@(posedge mclk) disable iff (sys_rst)
		(sub_in.valid && sub_in.line_start && is16) |=> (state == ST_GROUP && sub_idx == 2'd1);
	endproperty
	a_start16: assert property (p_start16) else $error("16 bpp line start not restarted");

	property p_top16;
		@(posedge mclk) disable iff (sys_rst)
		(take && is16 && sub_in.line_start) |=> acc[15:12] == $past(sub_in.nib);
	endproperty
	a_top16: assert property (p_top16) else $error("Top nibble not first sub-pixel");
endmodule
`default_nettype wire

// >>> verification/subpixel_source.sv
/*
 Model of the host controller that feeds 4-bit sub-pixels.
 Assumes the bench calls put and rest from one process.
*/
`timescale 1ns/1ps
`default_nettype none
module subpixel_source (
	input wire logic mclk,
	output pixel_asm_pkg::sub_in_t sub
);
	initial sub = '0;
	task automatic put(input logic ls, input logic [3:0] n);
		@(posedge mclk);
		sub <= '{1'b1, ls, n};
	endtask
	// Idle data keeps toggling so a stale nibble is never taken
	task automatic rest();
		@(posedge mclk);
		sub <= '{1'b0, 1'b0, ~sub.nib};
	endtask
endmodule
`default_nettype wire

// >>> verification/direct_dac_pixel_assembler_test.sv
/*
 Self-checking bench for the direct-colour pixel assembler.
 Assumes the package, design and sub-pixel source are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module direct_dac_pixel_assembler_test;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] video_type = 2'h0;
	pixel_asm_pkg::sub_in_t sub;
	pixel_asm_pkg::rgb5_t dac_rgb;
	logic pix_valid;
	logic word_valid;
	logic [15:0] pix;
	logic [31:0] word;
	logic [15:0] pq[$];
	logic [31:0] wq[$];
	int n_fail = 0;
	int compares = 0;
	subpixel_source src (.mclk(mclk), .sub(sub));
	direct_dac_pixel_assembler dut (.mclk(mclk), .sys_rst(sys_rst),
		.video_type(video_type), .sub_in(sub), .pix_valid(pix_valid), .pix(pix),
		.dac_rgb(dac_rgb), .word_valid(word_valid), .word(word));
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) begin
		if (pix_valid === 1'b1) pq.push_back(pix);
		if (word_valid === 1'b1) wq.push_back(word);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One line, first nibble flagged as line start
	task automatic send(input logic [3:0] n[$]);
		foreach (n[i]) src.put(i == 0, n[i]);
		repeat (4) src.rest();
	endtask
	task automatic test_12bpp();
		pq.delete();
		wq.delete();
		video_type <= pixel_asm_pkg::VT_DAC12;
		send('{4'h9, 4'h9, 4'h1, 4'h2});
		send('{4'hF, 4'hE, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7});
		chk(32'(pq.size()), 32'h0000_0002);
		chk(32'(pq[0]), 32'h0000_0321);
		chk(32'(pq[1]), 32'h0000_0654);
		chk(32'(dac_rgb), 32'h0000_10A6);
		chk(32'(wq.size()), 32'h0000_0000);
		$display("test_12bpp done");
	endtask
	task automatic test_16bpp();
		pq.delete();
		wq.delete();
		video_type <= pixel_asm_pkg::VT_DAC16;
		send('{4'h5, 4'h1, 4'h2, 4'h3, 4'h8, 4'h4, 4'h5, 4'h6, 4'hC, 4'h7});
		chk(32'(pq.size()), 32'h0000_0002);
		chk(32'(pq[0]), 32'h0000_5321);
		chk(32'(pq[1]), 32'h0000_8654);
		chk(32'(dac_rgb), 32'h0000_52B6);
		chk(32'(wq.size()), 32'h0000_0001);
		chk(wq[0], 32'h8654_5321);
		$display("test_16bpp done");
	endtask
	// Next line starts right after a pair completes
	task automatic test_16bpp_lines();
		logic [3:0] n[$];
		n = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
		wq.delete();
		foreach (n[i]) src.put(i == 0 || i == 8, n[i]);
		repeat (4) src.rest();
		chk(32'(wq.size()), 32'h0000_0001);
		chk(wq[0], 32'h5876_1432);
		$display("test_16bpp_lines done");
	endtask
	task automatic test_other_modes();
		for (int vt = 0; vt < 2; vt++) begin
			pq.delete();
			video_type <= 2'(vt);
			send('{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6});
			chk(32'(pq.size()), 32'h0000_0000);
		end
		$display("test_other_modes done");
	endtask
	task automatic give_verdict();
		$display("compares %0d, n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		test_12bpp();
		test_16bpp();
		test_16bpp_lines();
		test_other_modes();
		give_verdict();
	end
	// Whole run is well under a thousand cycles
	initial begin
		#20000;
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
